// *** core/framer_cfg.svh ***
// constants for the capture record framer: type codes, field positions, sizes
`ifndef FRAMER_CFG_SVH
`define FRAMER_CFG_SVH

// record type codes carried in the low seven bits of the type byte
`define ETHERNET_RECORD_TYPE 7'h02
`define COLOURED_ETHERNET_RECORD_TYPE 7'h0B
`define FILTER_COLOURED_ETHERNET_RECORD_TYPE 7'h10
// range held back for user extensions and internal use
`define RESERVED_TYPE_LO 7'h20
`define RESERVED_TYPE_HI 7'h2F

// field positions
`define TYPE_CODE_MSB 6
`define EXT_PRESENT_BIT 7

// byte index of each field inside the fixed header
`define HDR_IDX_TYPE 4'h8
`define HDR_IDX_FLAGS 4'h9
`define HDR_IDX_RLEN 4'hA
`define HDR_IDX_LOSS 4'hC
`define HDR_IDX_WLEN 4'hE
`define HDR_IDX_LAST 4'hF

// sizes in bytes, plus the extension count width in bits
`define FIXED_HDR_BYTES 16'h0010
`define EXT_HDR_BYTES 16'h0008
`define OFFPAD_BYTES 16'h0002
`define EXT_CNT_W 3

// value driven into the offset and pad bytes, and the loss count saturation limit
`define FILL_BYTE 8'h00
`define LOSS_MAX 16'hFFFF

// buffer shape: eight data bits plus an end-of-record flag
`define BUF_WIDTH 9
`define BUF_DEPTH 32

`endif

// *** core/framer_pkg.sv ***
// types shared by the capture record framer
package framer_pkg;

    // which Ethernet record flavour to build
    typedef enum logic [1:0] {
        KIND_PLAIN,
        KIND_COLOUR,
        KIND_FILTER_COLOUR
    } record_kind_t;

    // emission phases of one record
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_FIXED,
        ST_EXT,
        ST_OFFSET,
        ST_PAD,
        ST_PAYLOAD
    } framer_state_t;

    // whole state of the framer
    typedef struct packed {
        framer_state_t st;
        logic [15:0] cnt;
        logic [6:0] code;
        logic [2:0] ext_tot;
        logic [7:0] flags;
        logic [63:0] ts;
        logic [15:0] rlen;
        logic [15:0] lfield;
        logic [15:0] wlen;
        logic [15:0] pay_left;
        logic [15:0] loss;
    } framer_regs_t;

endpackage

// *** core/byte_stream_if.sv ***
// valid/ready stream carrier between the framer and its buffer
`timescale 1ns/1ps
`default_nettype none

interface byte_stream_if #(parameter int W = 9) ();
    logic valid;
    logic ready;
    logic [W-1:0] data;

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

`default_nettype wire

// *** core/record_fifo.sv ***
// buffer between the framer and the host path, read data from a register
`timescale 1ns/1ps
`default_nettype none

module record_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 32
) (
    input wire logic core_clk,
    input wire logic rst_sync_b,
    byte_stream_if.snk wr,
    byte_stream_if.src rd
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
        logic [WIDTH-1:0] out;
        logic out_v;
    } fifo_regs_t;

    fifo_regs_t q_reg;
    fifo_regs_t q_next;
    logic do_wr;
    logic do_ld;

    // full stalls the writer, output stage refills when empty or taken
    assign wr.ready = (q_reg.cnt != (AW+1)'(DEPTH));
    assign rd.valid = q_reg.out_v;
    assign rd.data = q_reg.out;
    assign do_wr = wr.valid && wr.ready;
    assign do_ld = (q_reg.cnt != '0) && (!q_reg.out_v || rd.ready);

    // next state of storage, pointers and output stage
    always_comb begin
        q_next = q_reg;
        if (do_wr) begin
            q_next.mem[q_reg.wp] = wr.data;
            q_next.wp = q_reg.wp + 1'b1;
        end
        if (do_ld) begin
            q_next.out = q_reg.mem[q_reg.rp];
            q_next.out_v = 1'b1;
            q_next.rp = q_reg.rp + 1'b1;
        end else if (rd.ready) begin
            q_next.out_v = 1'b0;
        end
        q_next.cnt = q_reg.cnt + (AW+1)'(do_wr) - (AW+1)'(do_ld);
    end

    always_ff @(posedge core_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            q_reg <= '0;
        end else begin
            q_reg <= q_next;
        end
    end

    // never more words held than the depth allows
    property p_fifo_bound;
        @(posedge core_clk) disable iff (!rst_sync_b)
        q_reg.cnt <= (AW+1)'(DEPTH);
    endproperty
    a_fifo_bound: assert property (p_fifo_bound) else $error("buffer count over depth");

    // a held output word stays put while the reader stalls
    property p_fifo_hold;
        @(posedge core_clk) disable iff (!rst_sync_b)
        rd.valid && !rd.ready |=> rd.valid && $stable(rd.data);
    endproperty
    a_fifo_hold: assert property (p_fifo_hold) else $error("output word changed under stall");

    c_fifo_full: cover property (@(posedge core_clk) disable iff (!rst_sync_b) !wr.ready);
endmodule

`default_nettype wire

// *** core/ethernet_capture_record_framer.sv ***
// ethernet capture record framer: builds header, extensions, offset, pad, payload
// Summary of operation
// - low seven type bits carry the record code, 2 for plain Ethernet records
// - type bit 7 set exactly when one or more extension headers follow
// - never emit the reserved type codes 32 to 47
// - coloured variant uses code 11, colour sits in the loss-count field
// - filter-coloured variant uses code 16, filter colour in loss-count field
// - one pad byte after offset, frame follows at once, IP header 32-bit aligned
// - payload equals record length minus 16, extensions, and 2 offset/pad bytes
// - record length is total record bytes, next record starts that far on
// - plain records carry packets dropped on host overload since previous record
// - each extension header is 8 bytes, type bit 7 flags a further one
`include "framer_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module ethernet_capture_record_framer (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic hdr_valid,
    output logic hdr_ready,
    input wire framer_pkg::record_kind_t hdr_kind,
    input wire logic [63:0] hdr_timestamp,
    input wire logic [7:0] hdr_flags,
    input wire logic [15:0] hdr_wire_len,
    input wire logic [15:0] hdr_colour,
    input wire logic [2:0] hdr_ext_count,
    input wire logic [15:0] hdr_capture_len,
    input wire logic drop_pulse,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [7:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [7:0] out_data,
    output logic out_last
);
    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    logic rst_meta_reg;
    logic rst_sync_b;

    // async assert, release through two flops
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta_reg <= 1'b0;
            rst_sync_b <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_b <= rst_meta_reg;
        end
    end

    // ------------------------------------------------------------
    // record builder
    // ------------------------------------------------------------
    framer_pkg::framer_regs_t q_reg;
    framer_pkg::framer_regs_t q_next;
    byte_stream_if #(.W(`BUF_WIDTH)) push ();
    byte_stream_if #(.W(`BUF_WIDTH)) pop ();
    logic take_hdr;
    logic do_push;
    logic push_last;
    logic [7:0] push_byte;
    logic [7:0] hdr_byte;
    logic ext_more;
    logic [15:0] ext_bytes;
    logic [6:0] kind_code;

    assign hdr_ready = (q_reg.st == framer_pkg::ST_IDLE);
    assign take_hdr = hdr_valid && hdr_ready;
    assign ext_bytes = {10'h000, q_reg.ext_tot, 3'h0};
    assign ext_more = (q_reg.cnt[5:3] != (q_reg.ext_tot - 3'h1));
    assign in_ready = ((q_reg.st == framer_pkg::ST_EXT) || (q_reg.st == framer_pkg::ST_PAYLOAD))
        && push.ready;
    assign do_push = push.valid && push.ready;

    // code chosen only from the three Ethernet flavours
    always_comb begin
        case (hdr_kind)
            framer_pkg::KIND_COLOUR: kind_code = `COLOURED_ETHERNET_RECORD_TYPE;
            framer_pkg::KIND_FILTER_COLOUR: kind_code = `FILTER_COLOURED_ETHERNET_RECORD_TYPE;
            default: kind_code = `ETHERNET_RECORD_TYPE;
        endcase
    end

    // fixed header byte by index, most significant byte first
    always_comb begin
        case (q_reg.cnt[3:0])
            4'h0: hdr_byte = q_reg.ts[63:56];
            4'h1: hdr_byte = q_reg.ts[55:48];
            4'h2: hdr_byte = q_reg.ts[47:40];
            4'h3: hdr_byte = q_reg.ts[39:32];
            4'h4: hdr_byte = q_reg.ts[31:24];
            4'h5: hdr_byte = q_reg.ts[23:16];
            4'h6: hdr_byte = q_reg.ts[15:8];
            4'h7: hdr_byte = q_reg.ts[7:0];
            `HDR_IDX_TYPE: hdr_byte = {(q_reg.ext_tot != 3'h0), q_reg.code};
            `HDR_IDX_FLAGS: hdr_byte = q_reg.flags;
            4'hA: hdr_byte = q_reg.rlen[15:8];
            4'hB: hdr_byte = q_reg.rlen[7:0];
            4'hC: hdr_byte = q_reg.lfield[15:8];
            4'hD: hdr_byte = q_reg.lfield[7:0];
            4'hE: hdr_byte = q_reg.wlen[15:8];
            default: hdr_byte = q_reg.wlen[7:0];
        endcase
    end

    // byte offered to the buffer in each phase
    always_comb begin
        push.valid = 1'b0;
        push_byte = `FILL_BYTE;
        push_last = 1'b0;
        case (q_reg.st)
            framer_pkg::ST_FIXED: begin
                push.valid = 1'b1;
                push_byte = hdr_byte;
            end
            framer_pkg::ST_EXT: begin
                push.valid = in_valid;
                push_byte = in_data;
                if (q_reg.cnt[2:0] == 3'h0) begin
                    push_byte = {ext_more, in_data[6:0]};
                end
            end
            framer_pkg::ST_OFFSET: begin
                push.valid = 1'b1;
            end
            framer_pkg::ST_PAD: begin
                push.valid = 1'b1;
                push_last = (q_reg.pay_left == 16'h0000);
            end
            framer_pkg::ST_PAYLOAD: begin
                push.valid = in_valid;
                push_byte = in_data;
                push_last = (q_reg.pay_left == 16'h0001);
            end
            default: begin
                push.valid = 1'b0;
            end
        endcase
    end
    assign push.data = {push_last, push_byte};

    // phase sequencing and loss counting
    always_comb begin
        q_next = q_reg;
        // drop counter saturates; a drop in the snapshot cycle is kept
        if (take_hdr) begin
            q_next.loss = drop_pulse ? 16'h0001 : 16'h0000;
        end else if (drop_pulse && (q_reg.loss != `LOSS_MAX)) begin
            q_next.loss = q_reg.loss + 16'h0001;
        end
        case (q_reg.st)
            framer_pkg::ST_IDLE: begin
                if (take_hdr) begin
                    q_next.st = framer_pkg::ST_FIXED;
                    q_next.cnt = 16'h0000;
                    q_next.code = kind_code;
                    q_next.ext_tot = hdr_ext_count;
                    q_next.flags = hdr_flags;
                    q_next.ts = hdr_timestamp;
                    q_next.wlen = hdr_wire_len;
                    q_next.pay_left = hdr_capture_len;
                    q_next.lfield = (hdr_kind == framer_pkg::KIND_PLAIN) ? q_reg.loss
                        : hdr_colour;
                    q_next.rlen = `FIXED_HDR_BYTES + {10'h000, hdr_ext_count, 3'h0}
                        + `OFFPAD_BYTES + hdr_capture_len;
                end
            end
            framer_pkg::ST_FIXED: begin
                if (do_push) begin
                    q_next.cnt = q_reg.cnt + 16'h0001;
                    if (q_reg.cnt[3:0] == `HDR_IDX_LAST) begin
                        q_next.cnt = 16'h0000;
                        q_next.st = (q_reg.ext_tot != 3'h0) ? framer_pkg::ST_EXT
                            : framer_pkg::ST_OFFSET;
                    end
                end
            end
            framer_pkg::ST_EXT: begin
                if (do_push) begin
                    q_next.cnt = q_reg.cnt + 16'h0001;
                    if (q_reg.cnt == ext_bytes - 16'h0001) begin
                        q_next.st = framer_pkg::ST_OFFSET;
                    end
                end
            end
            framer_pkg::ST_OFFSET: begin
                if (do_push) begin
                    q_next.st = framer_pkg::ST_PAD;
                end
            end
            framer_pkg::ST_PAD: begin
                if (do_push) begin
                    q_next.st = (q_reg.pay_left == 16'h0000) ? framer_pkg::ST_IDLE
                        : framer_pkg::ST_PAYLOAD;
                end
            end
            framer_pkg::ST_PAYLOAD: begin
                if (do_push) begin
                    q_next.pay_left = q_reg.pay_left - 16'h0001;
                    if (q_reg.pay_left == 16'h0001) begin
                        q_next.st = framer_pkg::ST_IDLE;
                    end
                end
            end
            default: begin
                q_next.st = framer_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            q_reg <= '0;
        end else begin
            q_reg <= q_next;
        end
    end

    // ------------------------------------------------------------
    // output buffer
    // ------------------------------------------------------------
    record_fifo #(.WIDTH(`BUF_WIDTH), .DEPTH(`BUF_DEPTH)) u_fifo (
        .core_clk(core_clk),
        .rst_sync_b(rst_sync_b),
        .wr(push.snk),
        .rd(pop.src)
    );

    assign pop.ready = out_ready;
    assign out_valid = pop.valid;
    assign out_data = pop.data[7:0];
    assign out_last = pop.data[8];

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_sync_b);
    logic type_slot;
    assign type_slot = do_push && (q_reg.st == framer_pkg::ST_FIXED)
        && (q_reg.cnt[3:0] == `HDR_IDX_TYPE);
    // any record that is not one of the coloured kinds must go out with the plain code
    property p_type_code;
        type_slot && (q_reg.code != `COLOURED_ETHERNET_RECORD_TYPE)
            && (q_reg.code != `FILTER_COLOURED_ETHERNET_RECORD_TYPE)
        |-> push_byte[`TYPE_CODE_MSB:0] == `ETHERNET_RECORD_TYPE;
    endproperty
    a_type_code: assert property (p_type_code) else $error("plain record type code wrong");
    property p_ext_flag;
        type_slot |-> push_byte[`EXT_PRESENT_BIT] == (q_reg.ext_tot != 3'h0);
    endproperty
    a_ext_flag: assert property (p_ext_flag) else $error("extension flag wrong");
    property p_no_reserved;
        type_slot |-> !(push_byte[6:0] inside {[`RESERVED_TYPE_LO:`RESERVED_TYPE_HI]});
    endproperty
    a_no_reserved: assert property (p_no_reserved) else $error("reserved type code emitted");
    property p_colour_rec;
        take_hdr && (hdr_kind == framer_pkg::KIND_COLOUR) |=>
            q_reg.code == `COLOURED_ETHERNET_RECORD_TYPE && q_reg.lfield == $past(hdr_colour);
    endproperty
    a_colour_rec: assert property (p_colour_rec) else $error("coloured record wrong");
    property p_filter_rec;
        take_hdr && (hdr_kind == framer_pkg::KIND_FILTER_COLOUR) |=>
            q_reg.code == `FILTER_COLOURED_ETHERNET_RECORD_TYPE
            && q_reg.lfield == $past(hdr_colour);
    endproperty
    a_filter_rec: assert property (p_filter_rec) else $error("filter record wrong");
    // the offset byte is always followed by the zero pad byte
    property p_pad_order;
        do_push && (q_reg.st == framer_pkg::ST_OFFSET)
        |=> (q_reg.st == framer_pkg::ST_PAD) && push_byte == `FILL_BYTE;
    endproperty
    a_pad_order: assert property (p_pad_order) else $error("pad byte missing or nonzero");
    property p_rlen;
        take_hdr |=> q_reg.rlen == `FIXED_HDR_BYTES + `OFFPAD_BYTES
            + 16'($past(hdr_ext_count)) * `EXT_HDR_BYTES + $past(hdr_capture_len);
    endproperty
    a_rlen: assert property (p_rlen) else $error("record length wrong");
    property p_loss;
        take_hdr && (hdr_kind == framer_pkg::KIND_PLAIN) |=> q_reg.lfield == $past(q_reg.loss);
    endproperty
    a_loss: assert property (p_loss) else $error("loss field wrong");
    property p_ext_chain;
        do_push && (q_reg.st == framer_pkg::ST_EXT) && (q_reg.cnt[2:0] == 3'h0)
        |-> push_byte[7] == (q_reg.cnt[5:3] != q_reg.ext_tot - 3'h1);
    endproperty
    a_ext_chain: assert property (p_ext_chain) else $error("extension chain bit wrong");
    c_plain_ext: cover property (type_slot && push_byte == {1'b1, `ETHERNET_RECORD_TYPE});
    c_colour: cover property (take_hdr && hdr_kind == framer_pkg::KIND_COLOUR);
    c_filter_end: cover property (do_push && push_last
        && q_reg.code == `FILTER_COLOURED_ETHERNET_RECORD_TYPE);
endmodule

`default_nettype wire

// *** testbench/host_sink_model.sv ***
// host storage side model: takes framed bytes with prompt, random or slow acceptance
`timescale 1ns/1ps
`default_nettype none

module host_sink_model (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic [1:0] stall_mode,
    input wire logic out_valid,
    input wire logic [7:0] out_data,
    input wire logic out_last,
    output logic out_ready,
    output logic got_valid,
    output logic [7:0] got_data,
    output logic got_last
);
    logic [31:0] seed_reg;
    logic [3:0] slow_reg;

    // ----------------------------------------------------------------
    // acceptance and capture
    // ----------------------------------------------------------------
    // every accepted byte goes to storage raw; offset contents are never interpreted
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            seed_reg <= 32'h7966B721;
            slow_reg <= 4'h0;
            out_ready <= 1'b0;
            got_valid <= 1'b0;
            got_data <= 8'h00;
            got_last <= 1'b0;
        end else begin
            seed_reg <= {seed_reg[30:0], 1'b0} ^ (seed_reg[31] ? 32'h04C11DB7 : 32'h0);
            slow_reg <= slow_reg + 4'h1;
            got_valid <= out_valid && out_ready;
            got_data <= out_data;
            got_last <= out_last;
            case (stall_mode)
                2'h0: out_ready <= 1'b1;
                2'h1: out_ready <= seed_reg[0];
                default: out_ready <= (slow_reg == 4'hF); // long stalls fill the buffer
            endcase
        end
    end
endmodule

`default_nettype wire

// *** testbench/tb_top.sv ***
// self-checking bench for the capture record framer
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic hdr_valid = 1'b0;
    logic hdr_ready;
    framer_pkg::record_kind_t hdr_kind = framer_pkg::KIND_PLAIN;
    logic [63:0] hdr_timestamp = 64'h0;
    logic [7:0] hdr_flags = 8'h00;
    logic [15:0] hdr_wire_len = 16'h0000;
    logic [15:0] hdr_colour = 16'h0000;
    logic [2:0] hdr_ext_count = 3'h0;
    logic [15:0] hdr_capture_len = 16'h0000;
    logic drop_pulse = 1'b0;
    logic drop_en = 1'b0;
    logic in_valid = 1'b0;
    logic in_ready;
    logic [7:0] in_data = 8'h00;
    logic out_valid, out_ready, out_last, got_valid, got_last;
    logic [7:0] out_data, got_data;
    logic [1:0] stall_mode = 2'h0;
    logic [31:0] seed = 32'h7966B721;
    logic [31:0] drop_seed = 32'h7966B721;
    logic [15:0] loss_cnt = 16'h0000;
    logic [15:0] loss_q [$];
    int err_count = 0;
    int comparisons = 0;

    ethernet_capture_record_framer ethernet_capture_record_framer_inst (
        .core_clk(core_clk), .rst_b(rst_b), .hdr_valid(hdr_valid), .hdr_ready(hdr_ready),
        .hdr_kind(hdr_kind), .hdr_timestamp(hdr_timestamp), .hdr_flags(hdr_flags),
        .hdr_wire_len(hdr_wire_len), .hdr_colour(hdr_colour), .hdr_ext_count(hdr_ext_count),
        .hdr_capture_len(hdr_capture_len), .drop_pulse(drop_pulse), .in_valid(in_valid),
        .in_ready(in_ready), .in_data(in_data), .out_valid(out_valid), .out_ready(out_ready),
        .out_data(out_data), .out_last(out_last));

    host_sink_model host_sink_model_inst (
        .core_clk(core_clk), .rst_b(rst_b), .stall_mode(stall_mode), .out_valid(out_valid),
        .out_data(out_data), .out_last(out_last), .out_ready(out_ready),
        .got_valid(got_valid), .got_data(got_data), .got_last(got_last));

    // ----------------------------------------------------------------
    // clock, random source, drop pulses and expected loss count
    // ----------------------------------------------------------------
    initial begin
        forever #50 core_clk = ~core_clk;
    end

    function automatic logic [31:0] lfsr_next(input logic [31:0] x);
        return {x[30:0], 1'b0} ^ (x[31] ? 32'h04C11DB7 : 32'h0);
    endfunction

    function automatic logic [31:0] rnd();
        seed = lfsr_next(seed);
        return seed;
    endfunction

    // drops arrive at random; the count is snapshotted and restarted at every take
    always @(posedge core_clk) begin
        drop_seed <= lfsr_next(drop_seed);
        drop_pulse <= drop_en && (drop_seed[3:0] == 4'h0);
        if (hdr_valid === 1'b1 && hdr_ready === 1'b1) begin
            loss_q.push_back(loss_cnt);
            loss_cnt <= {15'h0, drop_pulse};
        end else if (drop_pulse && loss_cnt != 16'hFFFF) begin
            loss_cnt <= loss_cnt + 16'h1;
        end
    end

    // ----------------------------------------------------------------
    // compare, verdict and timeout
    // ----------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test();
        if (err_count == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic timed_out();
        err_count++;
        end_of_test();
    endtask

    // ----------------------------------------------------------------
    // one record: request, byte source, host capture, then field checks
    // ----------------------------------------------------------------
    task automatic run_record(input framer_pkg::record_kind_t kind, input logic [2:0] ext,
                              input logic [15:0] clen, input logic [1:0] mode);
        logic [7:0] xb [$];
        logic [7:0] got [$];
        logic [7:0] exp [$];
        logic [15:0] rlen, lf, colour, wlen;
        logic [63:0] ts;
        logic [7:0] flags;
        logic [6:0] code;
        int n;
        int m;
        int k;
        ts = {rnd(), rnd()};
        colour = 16'(rnd());
        flags = 8'(rnd());
        wlen = clen + 16'h0004;
        for (int i = 0; i < 8 * ext + clen; i++)
            xb.push_back(8'(rnd()));
        @(posedge core_clk);
        stall_mode <= mode;
        hdr_valid <= 1'b1;
        hdr_kind <= kind;
        hdr_timestamp <= ts;
        hdr_flags <= flags;
        hdr_wire_len <= wlen;
        hdr_colour <= colour;
        hdr_ext_count <= ext;
        hdr_capture_len <= clen;
        fork
            begin
                n = 0;
                do begin
                    @(negedge core_clk);
                    n++;
                end while (hdr_ready !== 1'b1 && n < 3000);
                if (n >= 3000) timed_out();
                @(posedge core_clk);
                hdr_valid <= 1'b0;
            end
            begin
                foreach (xb[i]) begin
                    if (rnd() % 5 == 0) begin
                        in_valid <= 1'b0;
                        @(posedge core_clk);
                    end
                    in_valid <= 1'b1;
                    in_data <= xb[i];
                    m = 0;
                    do begin
                        @(negedge core_clk);
                        m++;
                    end while (in_ready !== 1'b1 && m < 5000);
                    if (m >= 5000) timed_out();
                    @(posedge core_clk);
                end
                in_valid <= 1'b0;
            end
            begin
                k = 0;
                while (k < 20000) begin
                    @(negedge core_clk);
                    k++;
                    if (got_valid === 1'b1) begin
                        got.push_back(got_data);
                        if (got_last === 1'b1) break;
                    end
                end
                if (k >= 20000) timed_out();
            end
        join
        // expected image built from the record layout
        code = (kind == framer_pkg::KIND_PLAIN) ? 7'h02 :
               (kind == framer_pkg::KIND_COLOUR) ? 7'h0B : 7'h10;
        lf = loss_q.pop_front();
        if (kind != framer_pkg::KIND_PLAIN) lf = colour;
        rlen = 16'h0012 + {10'h0, ext, 3'h0} + clen;
        for (int i = 0; i < 8; i++)
            exp.push_back(ts[63 - 8 * i -: 8]);
        exp.push_back({ext != 3'h0, code});
        exp.push_back(flags);
        exp.push_back(rlen[15:8]);
        exp.push_back(rlen[7:0]);
        exp.push_back(lf[15:8]);
        exp.push_back(lf[7:0]);
        exp.push_back(wlen[15:8]);
        exp.push_back(wlen[7:0]);
        foreach (xb[i]) begin
            if (i == 8 * ext) begin
                exp.push_back(8'h00);
                exp.push_back(8'h00);
            end
            if (i < 8 * ext && i % 8 == 0) exp.push_back({(i / 8) < (ext - 1), xb[i][6:0]});
            else exp.push_back(xb[i]);
        end
        if (clen == 16'h0) begin
            exp.push_back(8'h00);
            exp.push_back(8'h00);
        end
        check(16'(got.size()), rlen);
        if (got.size() == exp.size()) begin
            check(got[8][6:0], code);
            check(got[8][7], ext != 3'h0);
            check(got[8][6:4] == 3'h2, 1'b0);
            if (kind == framer_pkg::KIND_COLOUR) check({got[12], got[13]}, colour);
            if (kind == framer_pkg::KIND_FILTER_COLOUR) check({got[12], got[13]}, colour);
            if (kind == framer_pkg::KIND_PLAIN) check({got[12], got[13]}, lf);
            for (int j = 0; j < ext; j++) check(got[16 + 8 * j][7], j < ext - 1);
            check(got[16 + 8 * ext], 8'h00);
            check(got[17 + 8 * ext], 8'h00);
            foreach (got[i]) check(got[i], exp[i]);
        end
    endtask

    // ----------------------------------------------------------------
    // main sequence: corner records, then random back-to-back records
    // ----------------------------------------------------------------
    initial begin
        logic [31:0] r;
        repeat (3) @(posedge core_clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge core_clk);
        drop_en <= 1'b1;
        run_record(framer_pkg::KIND_PLAIN, 3'h0, 16'h0000, 2'h0);
        run_record(framer_pkg::KIND_COLOUR, 3'h7, 16'h0028, 2'h2);
        run_record(framer_pkg::KIND_FILTER_COLOUR, 3'h1, 16'h0001, 2'h1);
        run_record(framer_pkg::KIND_PLAIN, 3'h3, 16'h003C, 2'h2);
        for (int i = 0; i < 14; i++) begin
            r = rnd();
            run_record(framer_pkg::record_kind_t'(2'(r % 3)), r[4:2], 16'(r[13:8]), 2'(r[15:14] % 3));
        end
        end_of_test();
    end
endmodule

`default_nettype wire
